// file: tmsrb_core.v
// Behaviour
// - selector 1h returns changeable-field mask bytes
// - selector 2h returns defaults, even when not ready
// - selector 3h saved values, else illegal request
// - saved after reset: unreadable store gives not ready
// - current falls back until parameters were sent
// - decode ten-byte mode sense block fields
// - ten-byte mode sense always supported
// - decode ten-byte read buffer block fields
// - read buffer never touches the medium
// - transfer mode field decoded per mode
// - combined mode: header then data, ID ignored
// - header: reserved byte, then full capacity
// - combined mode ends at smaller length
// - data mode: buffer ID picks source buffer
// - unsupported buffer ID gives illegal field
// - data mode ends at smaller length
// - data mode starts at offset, bad offset rejected
// - vendor mode fields are implementer defined
// - two-bit selector applies to page parameters
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "tmsrb_regs.vh"
module tmsrb_core (
	// clock, reset, enable
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_ce,
	// avalon-mm register slave
	input wire [4:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output reg [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	// events
	input wire i_hard_reset_evt,
	input wire i_mode_select_done,
	// command descriptor block, byte 0 in the top bits
	input wire [79:0] i_cdb,
	input wire i_cdb_valid,
	output wire o_cdb_ready,
	// parameter store and diagnostic buffer read ports
	output reg [23:0] o_rd_addr,
	output reg [1:0] o_par_sel,
	output reg o_par_rd,
	input wire [7:0] i_par_data,
	output reg [7:0] o_buf_id,
	output reg o_buf_rd,
	input wire [7:0] i_buf_data,
	// data in stream
	output reg [7:0] o_din_data,
	output reg o_din_valid,
	input wire i_din_ready,
	// command completion
	output reg o_done,
	output reg o_check,
	output reg [3:0] o_sense_key,
	output reg [7:0] o_asc,
	output reg o_dbd
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_FETCH = 5'h02;
	localparam [4:0] ST_WAIT = 5'h04;
	localparam [4:0] ST_HOLD = 5'h08;
	localparam [4:0] ST_DONE = 5'h10;
	// byte sources
	localparam [1:0] SRC_PAR = 2'h0;
	localparam [1:0] SRC_BUF = 2'h1;
	localparam [1:0] SRC_DESC = 2'h2;

	reg [4:0] state_reg;
	reg [31:0] ctrl_reg;
	reg [23:0] cap_reg;
	reg [7:0] nbuf_reg;
	reg [7:0] bound_reg;
	reg [5:0] page_code_reg;
	reg [15:0] page_len_reg;
	reg [23:0] last_len_reg;
	reg params_sent_reg;
	reg ack_reg;
	reg [1:0] src_reg;
	reg [23:0] idx_reg;
	reg [23:0] total_reg;
	reg [23:0] hdr_len_reg;
	reg [23:0] base_reg;
	reg [31:0] rdata_next;

	// decoded command fields
	wire [7:0] cdb_op = i_cdb[79:72];
	wire cdb_dbd = i_cdb[67];
	wire [1:0] cdb_pvs = i_cdb[63:62];
	wire [5:0] cdb_page = i_cdb[61:56];
	wire [15:0] cdb_ms_alloc = i_cdb[23:8];
	wire [2:0] cdb_rb_mode = i_cdb[66:64];
	wire [7:0] cdb_rb_id = i_cdb[63:56];
	wire [23:0] cdb_rb_off = i_cdb[55:32];
	wire [23:0] cdb_rb_alloc = i_cdb[31:8];
	wire saved_sup = ctrl_reg[`TMSRB_CTRL_SAVED_SUP];
	wire nv_ok = ctrl_reg[`TMSRB_CTRL_NV_OK];
	wire unit_ready = ctrl_reg[`TMSRB_CTRL_UNIT_READY];
	wire busy = ~state_reg[0];
	wire take_cdb = i_ce & i_cdb_valid & state_reg[0];

	// smaller of two lengths, used by every transfer kind
	function [23:0] min24;
		input [23:0] a;
		input [23:0] b;
		begin
			min24 = (a < b) ? a : b;
		end
	endfunction

	// offset acceptable under the reported alignment boundary
	function off_ok;
		input [23:0] off;
		input [7:0] bnd;
		input [23:0] cap;
		reg [23:0] mask;
		begin
			mask = (bnd >= 8'h18) ? 24'hFFFFFF :
				((24'h000001 << bnd[4:0]) - 24'h000001);
			if (bnd == `TMSRB_BOUNDARY_NONE)
				off_ok = (off == 24'h000000);
			else
				off_ok = (off <= cap) && ((off & mask) == 24'h000000);
		end
	endfunction

	// flag a check condition; errors skip the transfer and finish at once
	task set_check;
		input [3:0] key;
		input [7:0] code;
		begin
			o_check <= 1'b1;
			o_sense_key <= key;
			o_asc <= code;
			state_reg <= ST_DONE;
		end
	endtask
	assign o_cdb_ready = state_reg[0];
	// one wait cycle for every access keeps readdata registered
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;

	// register read mux
	always @* begin
		rdata_next = 32'h00000000;
		case (i_avs_address)
		`TMSRB_REG_CTRL: rdata_next = ctrl_reg;
		`TMSRB_REG_STATUS: rdata_next = {16'h0000, o_asc, o_sense_key,
			1'b0, params_sent_reg, o_check, busy};
		`TMSRB_REG_CAPACITY: rdata_next = {8'h00, cap_reg};
		`TMSRB_REG_NUM_BUF: rdata_next = {24'h000000, nbuf_reg};
		`TMSRB_REG_BOUNDARY: rdata_next = {24'h000000, bound_reg};
		`TMSRB_REG_PAGE: rdata_next = {page_len_reg, 10'h000, page_code_reg};
		`TMSRB_REG_LAST_LEN: rdata_next = {8'h00, last_len_reg};
		default: rdata_next = 32'h00000000;
		endcase
	end

	// avalon slave: accept on first cycle, answer on second
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_reg <= 1'b0;
			o_avs_readdata <= 32'h00000000;
			ctrl_reg <= `TMSRB_CTRL_RST;
			cap_reg <= `TMSRB_CAPACITY_RST;
			nbuf_reg <= `TMSRB_NUM_BUF_RST;
			bound_reg <= `TMSRB_BOUNDARY_RST;
			page_code_reg <= `TMSRB_PAGE_CODE_RST;
			page_len_reg <= `TMSRB_PAGE_LEN_RST;
		end else if (i_ce) begin
			ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
			if (i_avs_read & ~ack_reg)
				o_avs_readdata <= rdata_next;
			if (i_avs_write & ack_reg) begin
				case (i_avs_address)
				`TMSRB_REG_CTRL: ctrl_reg <= {29'h0, i_avs_writedata[2:0]};
				`TMSRB_REG_CAPACITY: cap_reg <= i_avs_writedata[23:0];
				`TMSRB_REG_NUM_BUF: nbuf_reg <= i_avs_writedata[7:0];
				`TMSRB_REG_BOUNDARY: bound_reg <= i_avs_writedata[7:0];
				`TMSRB_REG_PAGE: begin
					page_code_reg <= i_avs_writedata[5:0];
					page_len_reg <= i_avs_writedata[31:16];
				end
				default: ;
				endcase
			end
		end
	end

	// parameters-sent flag; a select done in the reset cycle wins
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			params_sent_reg <= 1'b0;
		else if (i_ce) begin
			if (i_mode_select_done)
				params_sent_reg <= 1'b1;
			else if (i_hard_reset_evt)
				params_sent_reg <= 1'b0;
		end
	end

	// command decode, checks and byte transfer sequencer
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			src_reg <= SRC_PAR;
			idx_reg <= 24'h000000;
			total_reg <= 24'h000000;
			hdr_len_reg <= 24'h000000;
			base_reg <= 24'h000000;
			last_len_reg <= 24'h000000;
			o_rd_addr <= 24'h000000;
			o_par_sel <= `TMSRB_PVS_CURRENT;
			o_par_rd <= 1'b0;
			o_buf_id <= 8'h00;
			o_buf_rd <= 1'b0;
			o_din_data <= 8'h00;
			o_din_valid <= 1'b0;
			o_done <= 1'b0;
			o_check <= 1'b0;
			o_sense_key <= `TMSRB_SK_NONE;
			o_asc <= `TMSRB_ASC_NONE;
			o_dbd <= 1'b0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			o_par_rd <= 1'b0;
			o_buf_rd <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (take_cdb) begin
					o_check <= 1'b0;
					o_sense_key <= `TMSRB_SK_NONE;
					o_asc <= `TMSRB_ASC_NONE;
					idx_reg <= 24'h000000;
					hdr_len_reg <= 24'h000000;
					base_reg <= 24'h000000;
					state_reg <= ST_FETCH;
					if (cdb_op == `TMSRB_OP_MODE_SENSE10) begin
						src_reg <= SRC_PAR;
						o_dbd <= cdb_dbd;
						total_reg <= min24({8'h00, cdb_ms_alloc},
							{8'h00, page_len_reg});
						// selector picks which store the page bytes come from
						case (cdb_pvs)
						`TMSRB_PVS_CHANGEABLE:
							o_par_sel <= `TMSRB_PVS_CHANGEABLE;
						`TMSRB_PVS_DEFAULT:
							o_par_sel <= `TMSRB_PVS_DEFAULT;
						`TMSRB_PVS_SAVED:
							o_par_sel <= `TMSRB_PVS_SAVED;
						default: begin
							// before any select, report saved or default
							if (params_sent_reg)
								o_par_sel <= `TMSRB_PVS_CURRENT;
							else if (saved_sup & nv_ok)
								o_par_sel <= `TMSRB_PVS_SAVED;
							else
								o_par_sel <= `TMSRB_PVS_DEFAULT;
						end
						endcase
						if (cdb_page != page_code_reg &&
							cdb_page != `TMSRB_PAGE_ALL) begin
							set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_BAD_CDB_FIELD);
						end else if (cdb_pvs == `TMSRB_PVS_SAVED &&
							!saved_sup) begin
							set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_NO_SAVING);
						end else if (cdb_pvs == `TMSRB_PVS_SAVED && !nv_ok) begin
							set_check(`TMSRB_SK_NOT_READY, `TMSRB_ASC_NOT_READY);
						end else if (cdb_pvs != `TMSRB_PVS_DEFAULT &&
							!unit_ready) begin
							// defaults alone stay reachable while not ready
							set_check(`TMSRB_SK_NOT_READY, `TMSRB_ASC_NOT_READY);
						end
					end else if (cdb_op == `TMSRB_OP_READ_BUFFER) begin
						// only a read port exists: the medium is never written
						o_buf_id <= 8'h00;
						case (cdb_rb_mode)
						`TMSRB_RB_COMBINED, `TMSRB_RB_VENDOR: begin
							// vendor mode reuses combined layout, ID ignored
							src_reg <= SRC_BUF;
							hdr_len_reg <= `TMSRB_RB_HDR_LEN;
							total_reg <= min24(cdb_rb_alloc,
								cap_reg + `TMSRB_RB_HDR_LEN);
						end
						`TMSRB_RB_DATA: begin
							src_reg <= SRC_BUF;
							o_buf_id <= cdb_rb_id;
							base_reg <= cdb_rb_off;
							total_reg <= min24(cdb_rb_alloc,
								cap_reg - cdb_rb_off);
							if (cdb_rb_id >= nbuf_reg) begin
								set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_BAD_CDB_FIELD);
							end else if (!off_ok(cdb_rb_off, bound_reg,
								cap_reg)) begin
								set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_BAD_CDB_FIELD);
							end
						end
						`TMSRB_RB_DESCRIPTOR: begin
							// unknown buffer reports an all-zero descriptor
							src_reg <= SRC_DESC;
							o_buf_id <= cdb_rb_id;
							hdr_len_reg <= `TMSRB_RB_DESC_LEN;
							total_reg <= min24(cdb_rb_alloc, `TMSRB_RB_DESC_LEN);
						end
						default: begin
							total_reg <= 24'h000000;
							set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_BAD_CDB_FIELD);
						end
						endcase
					end else begin
						total_reg <= 24'h000000;
						set_check(`TMSRB_SK_ILLEGAL, `TMSRB_ASC_BAD_OPCODE);
					end
				end
			end
			ST_FETCH: begin
				if (idx_reg == total_reg) begin
					state_reg <= ST_DONE;
				end else if (idx_reg < hdr_len_reg) begin
					// header and descriptor bytes need no memory access
					o_din_valid <= 1'b1;
					state_reg <= ST_HOLD;
					if (src_reg == SRC_DESC && o_buf_id >= nbuf_reg)
						o_din_data <= 8'h00;
					else case (idx_reg[1:0])
					2'h0: o_din_data <= (src_reg == SRC_DESC) ?
						bound_reg : 8'h00;
					2'h1: o_din_data <= cap_reg[23:16];
					2'h2: o_din_data <= cap_reg[15:8];
					default: o_din_data <= cap_reg[7:0];
					endcase
				end else begin
					o_rd_addr <= base_reg + idx_reg - hdr_len_reg;
					o_par_rd <= (src_reg == SRC_PAR);
					o_buf_rd <= (src_reg == SRC_BUF);
					state_reg <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				// stores answer in the same cycle as the read strobe
				o_din_data <= (src_reg == SRC_PAR) ? i_par_data : i_buf_data;
				o_din_valid <= 1'b1;
				state_reg <= ST_HOLD;
			end
			ST_HOLD: begin
				if (i_din_ready) begin
					o_din_valid <= 1'b0;
					idx_reg <= idx_reg + 24'h000001;
					state_reg <= ST_FETCH;
				end
			end
			ST_DONE: begin
				o_done <= 1'b1;
				last_len_reg <= idx_reg;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // tmsrb_core
`default_nettype wire

// file: tmsrb_regs.vh
`ifndef TMSRB_REGS_VH
`define TMSRB_REGS_VH
// command opcodes
`define TMSRB_OP_MODE_SENSE10 8'h5A
`define TMSRB_OP_READ_BUFFER 8'h3C
// page value selector codes
`define TMSRB_PVS_CURRENT 2'h0
`define TMSRB_PVS_CHANGEABLE 2'h1
`define TMSRB_PVS_DEFAULT 2'h2
`define TMSRB_PVS_SAVED 2'h3
`define TMSRB_PAGE_ALL 6'h3F
// read buffer transfer modes
`define TMSRB_RB_COMBINED 3'h0
`define TMSRB_RB_VENDOR 3'h1
`define TMSRB_RB_DATA 3'h2
`define TMSRB_RB_DESCRIPTOR 3'h3
`define TMSRB_RB_HDR_LEN 24'h000004
`define TMSRB_RB_DESC_LEN 24'h000004
`define TMSRB_BOUNDARY_NONE 8'hFF
// sense keys and additional sense codes
`define TMSRB_SK_NONE 4'h0
`define TMSRB_SK_NOT_READY 4'h2
`define TMSRB_SK_ILLEGAL 4'h5
`define TMSRB_ASC_NONE 8'h00
`define TMSRB_ASC_BAD_OPCODE 8'h20
`define TMSRB_ASC_BAD_CDB_FIELD 8'h24
`define TMSRB_ASC_NO_SAVING 8'h39
`define TMSRB_ASC_NOT_READY 8'h04
// register byte addresses
`define TMSRB_REG_CTRL 5'h00
`define TMSRB_REG_STATUS 5'h04
`define TMSRB_REG_CAPACITY 5'h08
`define TMSRB_REG_NUM_BUF 5'h0C
`define TMSRB_REG_BOUNDARY 5'h10
`define TMSRB_REG_PAGE 5'h14
`define TMSRB_REG_LAST_LEN 5'h18
// control register fields
`define TMSRB_CTRL_SAVED_SUP 0
`define TMSRB_CTRL_NV_OK 1
`define TMSRB_CTRL_UNIT_READY 2
// reset values
`define TMSRB_CTRL_RST 32'h00000006
`define TMSRB_CAPACITY_RST 24'h000100
`define TMSRB_NUM_BUF_RST 8'h01
`define TMSRB_BOUNDARY_RST 8'h00
`define TMSRB_PAGE_CODE_RST 6'h01
`define TMSRB_PAGE_LEN_RST 16'h000C
`endif

// file: tmsrb_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tmsrb_core_monitor (
	// clock, reset, enable
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_ce,
	// command and data in
	input wire [79:0] i_cdb,
	input wire i_cdb_valid,
	input wire o_cdb_ready,
	input wire [23:0] o_rd_addr,
	input wire [1:0] o_par_sel,
	input wire o_par_rd,
	input wire o_buf_rd,
	input wire [7:0] o_din_data,
	input wire o_din_valid,
	input wire i_din_ready,
	// completion
	input wire o_done,
	input wire o_check,
	input wire [3:0] o_sense_key,
	input wire [7:0] o_asc,
	input wire o_dbd
);
	wire take = i_cdb_valid && o_cdb_ready && i_ce;
	wire beat = o_din_valid && i_din_ready;
	wire is_rb = i_cdb[79:72] == 8'h3C;
	wire rsv = take && is_rb && i_cdb[66:64] >= 3'h4 && i_cdb[66:64] <= 3'h6;
	reg ms_reg, dbd_reg, dm_reg, cm_reg, first_reg;
	reg [1:0] pvs_reg;
	reg [23:0] alloc_reg, off_reg, beats_reg;
	// fields latched at take; no reset, every use waits for a take
	always @(posedge i_sys_clk) begin
		if (take) begin
			ms_reg <= i_cdb[79:72] == 8'h5A;
			dbd_reg <= i_cdb[67];
			pvs_reg <= i_cdb[63:62];
			dm_reg <= is_rb && i_cdb[66:64] == 3'h2;
			cm_reg <= is_rb && i_cdb[66:65] == 2'h0;
			off_reg <= i_cdb[55:32];
			alloc_reg <= is_rb ? i_cdb[31:8] : {8'h00, i_cdb[23:8]};
			beats_reg <= 24'h000000;
			first_reg <= 1'b1;
		end else begin
			if (beat)
				beats_reg <= beats_reg + 24'h000001;
			if (o_buf_rd)
				first_reg <= 1'b0;
		end
	end
	default clocking mon_cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	rsv_sense_a: assert property (rsv |-> ##1 (o_check &&
		o_sense_key == 4'h5 && o_asc == 8'h24) ##1 o_done)
		else $error("reserved mode sense wrong");
	rsv_quiet_a: assert property (rsv |-> (!o_din_valid && !o_buf_rd)[*3])
		else $error("reserved mode moved data");
	err_nodata_a: assert property (o_done && o_check |-> beats_reg == 0)
		else $error("error command sent data");
	len_cap_a: assert property (o_done |-> beats_reg <= alloc_reg)
		else $error("more bytes than allocation");
	dbd_echo_a: assert property (o_done && ms_reg |-> o_dbd == dbd_reg)
		else $error("suppress bit not reported");
	pvs_route_a: assert property (o_par_rd && ms_reg && pvs_reg != 2'h0
		|-> o_par_sel == pvs_reg)
		else $error("wrong value store selected");
	off_start_a: assert property (o_buf_rd && first_reg && dm_reg
		|-> o_rd_addr == off_reg)
		else $error("data mode start address wrong");
	hdr_zero_a: assert property (beat && cm_reg && beats_reg == 0
		|-> o_din_data == 8'h00)
		else $error("header byte zero not reserved");
	comb_base_a: assert property (o_buf_rd && first_reg && cm_reg
		|-> o_rd_addr == 24'h000000)
		else $error("combined data not from start");
	done_pulse_a: assert property (o_done |=> !o_done && o_cdb_ready)
		else $error("done not a single pulse");
	cover property (o_done && cm_reg && !o_check);
	cover property (o_done && o_check);
	cover property (o_done && ms_reg && !o_check);
endmodule // tmsrb_core_monitor
bind tmsrb_core tmsrb_core_monitor tmsrb_core_monitor_i (.i_sys_clk, .i_rst,
	.i_ce, .i_cdb, .i_cdb_valid, .o_cdb_ready, .o_rd_addr, .o_par_sel,
	.o_par_rd, .o_buf_rd, .o_din_data, .o_din_valid, .i_din_ready, .o_done,
	.o_check, .o_sense_key, .o_asc, .o_dbd);
`default_nettype wire

// file: tmsrb_init_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmsrb_init_model (
	// clock and pacing
	input wire i_sys_clk,
	input wire i_slow,
	// store and buffer read ports
	input wire [23:0] i_rd_addr,
	input wire [1:0] i_par_sel,
	input wire i_par_rd,
	input wire i_buf_rd,
	output logic [7:0] o_par_data,
	output logic [7:0] o_buf_data,
	// data in sink
	output logic o_din_ready
);
	logic ph_reg;
	logic [7:0] junk_reg;
	initial ph_reg = 1'b0;
	initial junk_reg = 8'h5A;
	// bytes stand only while the strobe is high, the core takes them at
	// the edge that ends the strobe; junk otherwise to catch late use
	assign o_par_data = i_par_rd ? {i_par_sel, i_rd_addr[5:0]} : junk_reg;
	assign o_buf_data = i_buf_rd ? i_rd_addr[7:0] + 8'h30 : ~junk_reg;
	always @(posedge i_sys_clk) begin
		junk_reg <= ~junk_reg;
		ph_reg <= !ph_reg;
		o_din_ready <= !i_slow || ph_reg;
	end
endmodule // tmsrb_init_model
`default_nettype wire

// file: tmsrb_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tmsrb_core_tb;
	// design stimulus and observation
	logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_slow = 1'b0;
	logic [4:0] i_avs_address = 5'h00;
	logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest;
	logic [31:0] i_avs_writedata = 32'h00000000, o_avs_readdata;
	logic i_hard_reset_evt = 1'b0, i_mode_select_done = 1'b0;
	logic [79:0] i_cdb = 80'h0;
	logic i_cdb_valid = 1'b0, o_cdb_ready, o_par_rd, o_buf_rd;
	logic [23:0] o_rd_addr;
	logic [1:0] o_par_sel;
	logic [7:0] i_par_data, o_buf_id, i_buf_data, o_din_data, o_asc;
	logic o_din_valid, i_din_ready, o_done, o_check, o_dbd;
	logic [3:0] o_sense_key;
	int num_errors = 0, comparisons = 0;
	logic [7:0] got[$], exp[$];
	tmsrb_core tmsrb_core_i (.i_sys_clk, .i_rst, .i_ce, .i_avs_address,
		.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
		.o_avs_waitrequest, .i_hard_reset_evt, .i_mode_select_done, .i_cdb,
		.i_cdb_valid, .o_cdb_ready, .o_rd_addr, .o_par_sel, .o_par_rd,
		.i_par_data, .o_buf_id, .o_buf_rd, .i_buf_data, .o_din_data,
		.o_din_valid, .i_din_ready, .o_done, .o_check, .o_sense_key, .o_asc,
		.o_dbd);
	tmsrb_init_model tmsrb_init_model_i (.i_sys_clk, .i_slow,
		.i_rd_addr(o_rd_addr), .i_par_sel(o_par_sel), .i_par_rd(o_par_rd),
		.i_buf_rd(o_buf_rd), .o_par_data(i_par_data),
		.o_buf_data(i_buf_data), .o_din_ready(i_din_ready));
	// clock and data in capture
	always #50 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk)
		if (o_din_valid === 1'b1 && i_din_ready === 1'b1)
			got.push_back(o_din_data);
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bad();
		num_errors++;
		$display("wrong value at %0t: wait ran out", $time);
		results();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bytes();
		chk(got.size(), exp.size());
		foreach (exp[k])
			if (k < got.size())
				chk(got[k], exp[k]);
	endtask
	task automatic chk_sense(input logic [12:0] e);
		chk({19'h00000, o_check, o_sense_key, o_asc}, {19'h00000, e});
	endtask
	// bus cycle held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_sys_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		@(negedge i_sys_clk);
		for (int n = 0; o_avs_waitrequest !== 1'b0; n++) begin
			@(negedge i_sys_clk);
			if (n == 50)
				bad();
		end
		@(posedge i_sys_clk);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask
	// one command from take to done pulse
	task automatic cmd(input logic [79:0] c);
		got = {};
		@(posedge i_sys_clk);
		i_cdb <= c;
		i_cdb_valid <= 1'b1;
		@(negedge i_sys_clk);
		for (int n = 0; o_cdb_ready !== 1'b1; n++) begin
			@(negedge i_sys_clk);
			if (n == 50)
				bad();
		end
		@(posedge i_sys_clk);
		i_cdb_valid <= 1'b0;
		for (int n = 0; o_done !== 1'b1; n++) begin
			@(negedge i_sys_clk);
			if (n == 3000)
				bad();
		end
	endtask
	function automatic logic [79:0] ms(input logic [1:0] s,
		input logic [5:0] pg, input logic [15:0] al, input logic dbd);
		return {8'h5A, 4'h0, dbd, 3'h0, s, pg, 32'h0, al, 8'h00};
	endfunction
	function automatic logic [79:0] rb(input logic [2:0] md,
		input logic [7:0] id, input logic [23:0] off, input logic [23:0] al);
		return {8'h3C, 5'h00, md, id, off, al, 8'h00};
	endfunction
	// expected streams: store bytes and buffer bytes
	task automatic pexp(input logic [1:0] s, input int n);
		exp = {};
		for (int k = 0; k < n; k++)
			exp.push_back({s, k[5:0]});
	endtask
	task automatic bexp(input int base, input int n);
		for (int k = 0; k < n; k++)
			exp.push_back(8'(base + k + 48));
	endtask
	task automatic t_regs();
		logic [4:0] a[6] = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
		logic [31:0] e[6] = '{32'h6, 32'h100, 32'h1, 32'h0, 32'hC0001, 32'h0};
		logic [31:0] q;
		bus(1'b1, 5'h1C, 32'hFFFFFFFF, q);
		foreach (a[k]) begin
			bus(1'b0, a[k], 32'h0, q);
			chk(q, e[k]);
		end
	endtask
	task automatic t_ms();
		logic [31:0] q;
		pexp(2'h1, 12);
		cmd(ms(2'h1, 6'h3F, 16'h0014, 1'b1));
		chk_bytes();
		chk(o_dbd, 1'b1);
		pexp(2'h2, 5);
		cmd(ms(2'h0, 6'h01, 16'h0005, 1'b0));
		chk_bytes();
		chk(o_dbd, 1'b0);
		i_slow <= 1'b1;
		pexp(2'h2, 12);
		cmd(ms(2'h2, 6'h01, 16'h0030, 1'b0));
		chk_bytes();
		i_slow <= 1'b0;
		exp = {};
		cmd(ms(2'h3, 6'h01, 16'h0010, 1'b0));
		chk_bytes();
		chk_sense({1'b1, 4'h5, 8'h39});
		bus(1'b1, 5'h00, 32'h7, q);
		pexp(2'h3, 3);
		cmd(ms(2'h3, 6'h01, 16'h0003, 1'b0));
		chk_bytes();
		@(posedge i_sys_clk);
		i_mode_select_done <= 1'b1;
		@(posedge i_sys_clk);
		i_mode_select_done <= 1'b0;
		pexp(2'h0, 2);
		cmd(ms(2'h0, 6'h01, 16'h0002, 1'b0));
		chk_bytes();
		@(posedge i_sys_clk);
		i_hard_reset_evt <= 1'b1;
		@(posedge i_sys_clk);
		i_hard_reset_evt <= 1'b0;
		pexp(2'h3, 2);
		cmd(ms(2'h0, 6'h01, 16'h0002, 1'b0));
		chk_bytes();
		bus(1'b1, 5'h00, 32'h5, q);
		cmd(ms(2'h3, 6'h01, 16'h0004, 1'b0));
		chk_sense({1'b1, 4'h2, 8'h04});
		bus(1'b1, 5'h00, 32'h3, q);
		pexp(2'h2, 4);
		cmd(ms(2'h2, 6'h01, 16'h0004, 1'b0));
		chk_bytes();
		cmd(ms(2'h0, 6'h01, 16'h0004, 1'b0));
		chk_sense({1'b1, 4'h2, 8'h04});
		bus(1'b1, 5'h00, 32'h6, q);
		cmd(ms(2'h1, 6'h02, 16'h0004, 1'b0));
		chk_sense({1'b1, 4'h5, 8'h24});
		cmd({8'h12, 72'h0});
		chk_sense({1'b1, 4'h5, 8'h20});
	endtask
	task automatic t_rb();
		logic [31:0] q;
		bus(1'b1, 5'h08, 32'h8, q);
		exp = '{8'h00, 8'h00, 8'h00, 8'h08};
		bexp(0, 2);
		cmd(rb(3'h0, 8'h05, 24'h000007, 24'h000006));
		chk_bytes();
		chk(o_buf_id, 8'h00);
		exp = '{8'h00, 8'h00, 8'h00, 8'h08};
		bexp(0, 8);
		cmd(rb(3'h1, 8'h00, 24'h000000, 24'h000064));
		chk_bytes();
		i_slow <= 1'b1;
		exp = {};
		bexp(2, 3);
		cmd(rb(3'h2, 8'h00, 24'h000002, 24'h000003));
		chk_bytes();
		i_slow <= 1'b0;
		exp = {};
		bexp(6, 2);
		cmd(rb(3'h2, 8'h00, 24'h000006, 24'h00000A));
		chk_bytes();
		cmd(rb(3'h2, 8'h01, 24'h000000, 24'h000004));
		chk_sense({1'b1, 4'h5, 8'h24});
		cmd(rb(3'h2, 8'h00, 24'h000009, 24'h000004));
		chk_sense({1'b1, 4'h5, 8'h24});
		bus(1'b1, 5'h10, 32'h1, q);
		cmd(rb(3'h2, 8'h00, 24'h000003, 24'h000001));
		chk_sense({1'b1, 4'h5, 8'h24});
		exp = {};
		bexp(4, 1);
		cmd(rb(3'h2, 8'h00, 24'h000004, 24'h000001));
		chk_bytes();
		bus(1'b0, 5'h18, 32'h0, q);
		chk(q, 32'h1);
		exp = '{8'h01, 8'h00, 8'h00, 8'h08};
		cmd(rb(3'h3, 8'h00, 24'h000000, 24'h000004));
		chk_bytes();
		for (int m = 4; m <= 6; m++) begin
			cmd(rb(3'(m), 8'h00, 24'h000000, 24'h000004));
			chk(got.size(), 0);
			chk_sense({1'b1, 4'h5, 8'h24});
		end
		bus(1'b0, 5'h04, 32'h0, q);
		chk(q, 32'h00002452);
	endtask
	// a low clock enable must hold the bus answer back
	task automatic t_ce();
		logic [31:0] q;
		@(posedge i_sys_clk);
		i_ce <= 1'b0;
		fork
			bus(1'b0, 5'h08, 32'h0, q);
			begin
				repeat (4) @(negedge i_sys_clk);
				chk(o_avs_waitrequest, 1'b1);
				@(posedge i_sys_clk);
				i_ce <= 1'b1;
			end
		join
		chk(q, 32'h8);
	endtask
	// reset for 20 cycles, then the scenarios
	initial begin
		repeat (20) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_regs();
		t_ms();
		t_rb();
		t_ce();
		results();
	end
endmodule // tmsrb_core_tb
`default_nettype wire
